/* File: logic/tmc_consts.svh */
// Timing counts and reset values for the transceiver mode controller
`ifndef TMC_CONSTS_SVH
`define TMC_CONSTS_SVH

// ----------------------------------------------------------------
// Clock
// ----------------------------------------------------------------
`define TMC_CLK_PERIOD_NS    100

// ----------------------------------------------------------------
// Times in ns (minimum hold, undervoltage detection, dominant timeout)
// ----------------------------------------------------------------
`define TMC_HOLD_NS          50000
`define TMC_UV_DET_NS        10000
`define TMC_TXD_DOM_NS       1000000

// Least times round up to whole cycles
`define TMC_HOLD_CYC    ((`TMC_HOLD_NS + `TMC_CLK_PERIOD_NS - 1) / `TMC_CLK_PERIOD_NS)
`define TMC_UV_DET_CYC  ((`TMC_UV_DET_NS + `TMC_CLK_PERIOD_NS - 1) / `TMC_CLK_PERIOD_NS)
`define TMC_TXD_DOM_CYC ((`TMC_TXD_DOM_NS + `TMC_CLK_PERIOD_NS - 1) / `TMC_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// Counter width and reset values
// ----------------------------------------------------------------
`define TMC_CNT_W            16
`define TMC_FLAGS_RST        5'h00
`define TMC_PINS_RST         10'h000

`endif

/* File: logic/tmc_pkg.sv */
// Types of the transceiver mode controller
package tmc_pkg;

  // Operating modes, one-hot
  typedef enum logic [4:0] {
    TMC_NORMAL  = 5'h01,
    TMC_RXONLY  = 5'h02,
    TMC_STANDBY = 5'h04,
    TMC_GOSLEEP = 5'h08,
    TMC_SLEEP   = 5'h10
  } tmc_mode_t;

  // Pin inputs travelling through the synchroniser together
  typedef struct packed {
    logic standby_control_n;
    logic mode_enable_in;
    logic transmit_data_in;
    logic bus_dominant;
    logic bus_wake;
    logic local_wake_in;
    logic core_uv;
    logic bat_uv;
    logic bat_connect;
    logic overtemp;
  } tmc_pins_t;

  // Internal flags
  typedef struct packed {
    logic powerup;
    logic wake;
    logic local_wake;
    logic failure;
    logic fail_ot;
  } tmc_flags_t;

endpackage

/* File: logic/tmc_persist.sv */
// Persistence counter: done once its condition has held for LIMIT cycles
`timescale 1ns/1ns
`default_nettype none
module tmc_persist #(
  parameter int          CNT_W = 16,
  parameter logic [15:0] LIMIT = 16'h0001
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // Condition and result
  input  wire logic i_run,
  output logic      o_done
);

  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic             done_ff;
  logic             nxt_done;

  // Restarts whenever the condition drops; saturates at the limit
  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_done = 1'b0;
    if (!i_run) begin
      nxt_cnt = '0;
    end else if (cnt_ff < CNT_W'(LIMIT)) begin
      nxt_cnt = cnt_ff + CNT_W'(1);
    end
    if (i_run && (nxt_cnt >= CNT_W'(LIMIT))) begin
      nxt_done = 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_ff  <= '0;
      done_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      done_ff <= nxt_done;
    end
  end

  assign o_done = done_ff;

endmodule
`default_nettype wire

/* File: logic/tmc_mode_ctrl.sv */
// Operating-mode controller of a high-speed CAN transceiver
//
// Notes on behaviour
// - Standby control and mode enable both high with no undervoltage give normal mode: transmit, receive, inhibit high.
// - Standby control high and mode enable low with no undervoltage give receive-only: transmitter off, receiver on, inhibit high.
// - Standby turns transmitter and receiver off, watches the bus at low power, floats split bias, keeps inhibit high.
// - In standby a bus or local wake-up is accepted and shown by pulling both error and receive pins low.
// - Mode enable high with standby control low and the power-up and wake flags clear gives go-to-sleep unless already asleep.
// - Go-to-sleep becomes sleep only after both mode inputs stay unchanged for the hold time with no wake-up or power-up.
// - Go-to-sleep behaves exactly like standby.
// - Sleep behaves like standby but floats the inhibit output.
// - Sleep is entered from go-to-sleep or on a core supply undervoltage lasting past the detection time, ignoring mode inputs.
// - Sleep is left on a wake-up, or on standby control high while no core undervoltage is flagged and no battery undervoltage is present.
// - With standby control low and flags clear a sleeping device stays asleep, otherwise enable low gives standby and high go-to-sleep.
// - The error pin shows a flag chosen by mode and never the undervoltage or dominant timeout flags.
// - The error pin is low while the shown flag is set and high while it is clear.
// - A battery undervoltage without core undervoltage gives standby, unless asleep with flags clear; recovery returns to the mode the inputs select.
// - A dominant timeout or overtemperature keeps the transmitter off until the failure flag clears.
// - Receive-only shows the power-up flag on the error pin, and entering normal mode clears it.
`timescale 1ns/1ns
`default_nettype none
`include "tmc_consts.svh"
module tmc_mode_ctrl
  import tmc_pkg::*;
#(
  parameter logic [15:0] HOLD_CYC    = 16'(`TMC_HOLD_CYC),
  parameter logic [15:0] UV_DET_CYC  = 16'(`TMC_UV_DET_CYC),
  parameter logic [15:0] TXD_DOM_CYC = 16'(`TMC_TXD_DOM_CYC)
) (
  // Clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_rst,
  // Controller side pins
  input  wire logic i_standby_control_n,
  input  wire logic i_mode_enable_in,
  input  wire logic i_transmit_data_in,
  output logic      o_receive_data_out,
  output logic      o_error_flag_out_n,
  // Bus side and analogue status
  input  wire logic i_bus_dominant,
  input  wire logic i_bus_wake,
  input  wire logic i_local_wake_in,
  input  wire logic i_core_uv,
  input  wire logic i_bat_uv,
  input  wire logic i_bat_connect,
  input  wire logic i_overtemp,
  // Drivers
  output logic      o_tx_enable,
  output logic      o_tx_dominant,
  output logic      o_rx_enable,
  output logic      o_lp_rx_enable,
  output logic      o_split_bias_out_oe,
  output logic      o_regulator_inhibit_out,
  output logic      o_regulator_inhibit_out_oe,
  output tmc_mode_t o_mode
);

  // ----------------------------------------------------------------
  // Input synchroniser
  // ----------------------------------------------------------------
  tmc_pins_t pins_raw;
  tmc_pins_t sync1_ff;
  tmc_pins_t sync2_ff;
  tmc_pins_t prev_ff;

  assign pins_raw = '{i_standby_control_n, i_mode_enable_in, i_transmit_data_in,
                      i_bus_dominant, i_bus_wake, i_local_wake_in, i_core_uv,
                      i_bat_uv, i_bat_connect, i_overtemp};

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      sync1_ff <= `TMC_PINS_RST;
      sync2_ff <= `TMC_PINS_RST;
      prev_ff  <= `TMC_PINS_RST;
    end else begin
      sync1_ff <= pins_raw;
      sync2_ff <= sync1_ff;
      prev_ff  <= sync2_ff;
    end
  end

  logic wake_evt;
  logic pwup_evt;
  logic lwake_evt;
  logic inputs_changed;

  assign lwake_evt      = sync2_ff.local_wake_in & ~prev_ff.local_wake_in;
  assign wake_evt       = (sync2_ff.bus_wake & ~prev_ff.bus_wake) | lwake_evt;
  assign pwup_evt       = sync2_ff.bat_connect & ~prev_ff.bat_connect;
  assign inputs_changed = (sync2_ff.standby_control_n != prev_ff.standby_control_n) ||
                          (sync2_ff.mode_enable_in != prev_ff.mode_enable_in);

  // ----------------------------------------------------------------
  // Persistence counters
  // ----------------------------------------------------------------
  tmc_mode_t mode_ff;
  logic      uv_ff;
  logic      hold_done;
  logic      uv_det_done;
  logic      uv_wait_done;
  logic      txd_dom_done;

  // Any change of the mode inputs drops i_run for a cycle, restarting the count
  tmc_persist #(.CNT_W(`TMC_CNT_W), .LIMIT(HOLD_CYC)) u_hold (
    .i_clk  (i_ref_clk),
    .i_rst  (i_rst),
    .i_run  ((mode_ff == TMC_GOSLEEP) && !inputs_changed),
    .o_done (hold_done)
  );

  tmc_persist #(.CNT_W(`TMC_CNT_W), .LIMIT(UV_DET_CYC)) u_uv_det (
    .i_clk  (i_ref_clk),
    .i_rst  (i_rst),
    .i_run  (sync2_ff.core_uv),
    .o_done (uv_det_done)
  );

  // Wake-up is blocked for one detection time after the undervoltage flag sets
  tmc_persist #(.CNT_W(`TMC_CNT_W), .LIMIT(UV_DET_CYC)) u_uv_wait (
    .i_clk  (i_ref_clk),
    .i_rst  (i_rst),
    .i_run  (uv_ff),
    .o_done (uv_wait_done)
  );

  tmc_persist #(.CNT_W(`TMC_CNT_W), .LIMIT(TXD_DOM_CYC)) u_txd_dom (
    .i_clk  (i_ref_clk),
    .i_rst  (i_rst),
    .i_run  (!sync2_ff.transmit_data_in && o_tx_enable),
    .o_done (txd_dom_done)
  );

  // ----------------------------------------------------------------
  // Flags and mode
  // ----------------------------------------------------------------
  tmc_flags_t flags_ff;
  tmc_flags_t nxt_flags;
  tmc_mode_t  nxt_mode;
  logic       nxt_uv;
  logic       wake_ok;
  logic       flags_set;

  assign wake_ok   = (!uv_ff || uv_wait_done) && (mode_ff != TMC_NORMAL) &&
                     (mode_ff != TMC_RXONLY);
  assign flags_set = flags_ff.powerup | flags_ff.wake;

  always_comb begin
    nxt_flags = flags_ff;
    nxt_uv    = uv_ff;
    nxt_mode  = mode_ff;
    // Clears first so that a coinciding set wins
    if (uv_ff && ((wake_ok && wake_evt) || pwup_evt)) begin
      nxt_uv = 1'b0;
    end
    if (uv_det_done) begin
      nxt_uv = 1'b1;
    end
    if (mode_ff == TMC_NORMAL) begin
      nxt_flags.powerup = 1'b0;
      nxt_flags.wake    = 1'b0;
    end
    if (mode_ff != TMC_NORMAL || pwup_evt) begin
      nxt_flags.local_wake = 1'b0;
    end
    if (pwup_evt || (uv_det_done && !uv_ff)) begin
      nxt_flags.wake = 1'b0;
    end
    if ((mode_ff == TMC_NORMAL && sync2_ff.transmit_data_in) ||
        (sync2_ff.transmit_data_in && sync2_ff.bus_dominant &&
         !sync2_ff.overtemp && !txd_dom_done)) begin
      nxt_flags.failure = 1'b0;
      nxt_flags.fail_ot = 1'b0;
    end
    if (pwup_evt) begin
      nxt_flags.powerup = 1'b1;
    end
    if (wake_ok && wake_evt) begin
      nxt_flags.wake = 1'b1;
    end
    if (lwake_evt && !flags_ff.powerup) begin
      nxt_flags.local_wake = 1'b1;
    end
    if (txd_dom_done || sync2_ff.overtemp) begin
      nxt_flags.failure = 1'b1;
    end
    if (sync2_ff.overtemp) begin
      nxt_flags.fail_ot = 1'b1;
    end
    // Mode selection in order of priority
    if (uv_ff) begin
      nxt_mode = TMC_SLEEP;
    end else if (sync2_ff.bat_uv) begin
      if (flags_set || mode_ff != TMC_SLEEP) begin
        nxt_mode = TMC_STANDBY;
      end
    end else if (sync2_ff.standby_control_n) begin
      nxt_mode = sync2_ff.mode_enable_in ? TMC_NORMAL : TMC_RXONLY;
    end else if (flags_set) begin
      nxt_mode = TMC_STANDBY;
    end else if (mode_ff == TMC_SLEEP) begin
      nxt_mode = TMC_SLEEP;
    end else if (!sync2_ff.mode_enable_in) begin
      nxt_mode = TMC_STANDBY;
    end else if (mode_ff == TMC_GOSLEEP && hold_done && !pwup_evt && !wake_evt) begin
      nxt_mode = TMC_SLEEP;
    end else begin
      nxt_mode = TMC_GOSLEEP;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      flags_ff <= `TMC_FLAGS_RST;
      uv_ff    <= 1'b0;
      mode_ff  <= TMC_STANDBY;
    end else begin
      flags_ff <= nxt_flags;
      uv_ff    <= nxt_uv;
      mode_ff  <= nxt_mode;
    end
  end

  // ----------------------------------------------------------------
  // Output drivers
  // ----------------------------------------------------------------
  logic nxt_rxd;
  logic nxt_err_n;
  logic nxt_tx_en;
  logic active;
  logic shown_flag;

  assign active = (mode_ff == TMC_NORMAL) || (mode_ff == TMC_RXONLY);

  always_comb begin
    nxt_tx_en = (mode_ff == TMC_NORMAL) && !flags_ff.failure;
    // Undervoltage and dominant timeout never reach the error pin
    case (mode_ff)
      TMC_NORMAL: shown_flag = flags_ff.local_wake;
      TMC_RXONLY: shown_flag = flags_ff.powerup | flags_ff.fail_ot;
      TMC_STANDBY,
      TMC_GOSLEEP,
      TMC_SLEEP:  shown_flag = flags_ff.wake;
      default:    shown_flag = 1'b0;
    endcase
    nxt_err_n = !shown_flag;
    nxt_rxd   = active ? !sync2_ff.bus_dominant : !flags_ff.wake;
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_tx_enable                <= 1'b0;
      o_tx_dominant              <= 1'b0;
      o_rx_enable                <= 1'b0;
      o_lp_rx_enable             <= 1'b1;
      o_split_bias_out_oe        <= 1'b0;
      o_regulator_inhibit_out    <= 1'b1;
      o_regulator_inhibit_out_oe <= 1'b1;
      o_receive_data_out         <= 1'b1;
      o_error_flag_out_n         <= 1'b1;
      o_mode                     <= TMC_STANDBY;
    end else begin
      o_tx_enable                <= nxt_tx_en;
      o_tx_dominant              <= nxt_tx_en && !sync2_ff.transmit_data_in;
      o_rx_enable                <= active;
      o_lp_rx_enable             <= !active;
      o_split_bias_out_oe        <= active;
      o_regulator_inhibit_out    <= 1'b1;
      o_regulator_inhibit_out_oe <= (mode_ff != TMC_SLEEP);
      o_receive_data_out         <= nxt_rxd;
      o_error_flag_out_n         <= nxt_err_n;
      o_mode                     <= mode_ff;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_normal_tx;
    @(posedge i_ref_clk) disable iff (i_rst)
      (mode_ff == TMC_NORMAL && !flags_ff.failure) |=> o_tx_enable && o_rx_enable;
  endproperty
  a_normal_tx: assert property (p_normal_tx) else $error("Normal mode without tx");

  property p_rxonly_notx;
    @(posedge i_ref_clk) disable iff (i_rst)
      (mode_ff == TMC_RXONLY) |=> !o_tx_enable && o_rx_enable && o_regulator_inhibit_out_oe;
  endproperty
  a_rxonly_notx: assert property (p_rxonly_notx) else $error("Receive-only drives tx");

  property p_lowpower;
    @(posedge i_ref_clk) disable iff (i_rst)
      (mode_ff == TMC_STANDBY || mode_ff == TMC_GOSLEEP) |=>
        !o_tx_enable && !o_rx_enable && !o_split_bias_out_oe && o_regulator_inhibit_out_oe;
  endproperty
  a_lowpower: assert property (p_lowpower) else $error("Standby outputs wrong");

  property p_wake_pins;
    @(posedge i_ref_clk) disable iff (i_rst)
      (flags_ff.wake && !active) |=> !o_error_flag_out_n && !o_receive_data_out;
  endproperty
  a_wake_pins: assert property (p_wake_pins) else $error("Wake-up not signalled");

  property p_sleep_inh;
    @(posedge i_ref_clk) disable iff (i_rst)
      (mode_ff == TMC_SLEEP) |=> !o_regulator_inhibit_out_oe;
  endproperty
  a_sleep_inh: assert property (p_sleep_inh) else $error("Inhibit driven in sleep");

  property p_sleep_entry;
    @(posedge i_ref_clk) disable iff (i_rst)
      (mode_ff != TMC_SLEEP) ##1 (mode_ff == TMC_SLEEP) |->
        $past(mode_ff) == TMC_GOSLEEP || $past(uv_ff);
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("Illegal sleep entry");

  property p_uv_sleep;
    @(posedge i_ref_clk) disable iff (i_rst)
      uv_ff |=> mode_ff == TMC_SLEEP;
  endproperty
  a_uv_sleep: assert property (p_uv_sleep) else $error("Undervoltage without sleep");

  property p_fail_tx;
    @(posedge i_ref_clk) disable iff (i_rst)
      flags_ff.failure |=> !o_tx_enable;
  endproperty
  a_fail_tx: assert property (p_fail_tx) else $error("Tx enabled with failure");

  property p_pwup_clr;
    @(posedge i_ref_clk) disable iff (i_rst)
      (mode_ff == TMC_NORMAL && !pwup_evt) |=> !flags_ff.powerup;
  endproperty
  a_pwup_clr: assert property (p_pwup_clr) else $error("Power-up not cleared");

endmodule
`default_nettype wire

/* File: tb/tmc_ctrl_model.sv */
// Behavioural model of the CAN controller driving the mode and transmit pins
`timescale 1ns/1ns
`default_nettype none
module tmc_ctrl_model (
  // Clock
  input  wire logic i_clk,
  // Requests from the bench
  input  wire logic i_stb_n_req,
  input  wire logic i_en_req,
  input  wire logic i_txd_req,
  // Pins towards the transceiver
  output var logic  o_standby_control_n,
  output var logic  o_mode_enable_in,
  output var logic  o_transmit_data_in
);
  initial begin
    o_standby_control_n = 1'b0;
    o_mode_enable_in    = 1'b0;
    o_transmit_data_in  = 1'b1;
  end

  // Pins move only after a falling edge and then stand still until the next request
  always @(negedge i_clk) begin
    o_standby_control_n <= i_stb_n_req;
    o_mode_enable_in    <= i_en_req;
    o_transmit_data_in  <= i_txd_req;
  end
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the transceiver mode controller
`timescale 1ns/1ns
`default_nettype none
module tb
  import tmc_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int D = 8;
  logic        clk, rst, stb_n_r, en_r, txd_r, bdom_r;
  logic        bwake, lwake, cuv, buv, bcon, ot;
  logic        stb_n, en, txd, rxd, errn, txen, txdom, rxen, lprx, spl, regulator_inhibit_out, inh_oe;
  tmc_mode_t   mode;
  logic [12:0] q[$];
  event        obs_ev;
  int          num_errors, num_checks, cyc, k;
  integer      seed;

  tmc_ctrl_model u_ctrl (
    .i_clk(clk), .i_stb_n_req(stb_n_r), .i_en_req(en_r), .i_txd_req(txd_r),
    .o_standby_control_n(stb_n), .o_mode_enable_in(en), .o_transmit_data_in(txd));

  tmc_mode_ctrl #(.HOLD_CYC(16'h0008), .UV_DET_CYC(16'h0004), .TXD_DOM_CYC(16'h0010)) u_dut (
    .i_ref_clk(clk), .i_rst(rst), .i_standby_control_n(stb_n), .i_mode_enable_in(en),
    .i_transmit_data_in(txd), .o_receive_data_out(rxd), .o_error_flag_out_n(errn),
    .i_bus_dominant(bdom_r), .i_bus_wake(bwake), .i_local_wake_in(lwake), .i_core_uv(cuv),
    .i_bat_uv(buv), .i_bat_connect(bcon), .i_overtemp(ot), .o_tx_enable(txen),
    .o_tx_dominant(txdom), .o_rx_enable(rxen), .o_lp_rx_enable(lprx),
    .o_split_bias_out_oe(spl), .o_regulator_inhibit_out(regulator_inhibit_out),
    .o_regulator_inhibit_out_oe(inh_oe), .o_mode(mode));

  // ----------------------------------------------------------------
  // Clock, hang guard and result monitor
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors = num_errors + 1;
      summarize();
    end
  end

  // Inhibit level itself never drops; only its enable floats the pin
  always @(obs_ev) begin
    chk({mode, txen, txdom, rxen, lprx, spl, inh_oe & regulator_inhibit_out, errn, rxd}, q.pop_front());
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [12:0] ex(tmc_mode_t m, logic fail, logic en_n, logic rx_lp);
    logic act;
    logic tx;
    act = (m == TMC_NORMAL) || (m == TMC_RXONLY);
    tx  = (m == TMC_NORMAL) && !fail;
    return {m, tx, tx & !txd_r, act, !act, act, m != TMC_SLEEP, en_n, act ? !bdom_r : rx_lp};
  endfunction

  task automatic pins(input logic s, input logic e);
    stb_n_r = s;
    en_r    = e;
  endtask

  task automatic step(input int n, input logic [12:0] exp);
    repeat (n) @(negedge clk);
    q.push_back(exp);
    ->obs_ev;
    #1;
  endtask

  task automatic to_sleep();
    pins(1'b0, 1'b1);
    step(D, ex(TMC_GOSLEEP, 1'b0, 1'b1, 1'b1));
    for (int i = 0; i < 40 && mode !== TMC_SLEEP; i++) @(negedge clk);
    step(1, ex(TMC_SLEEP, 1'b0, 1'b1, 1'b1));
  endtask

  task automatic done_test(input string name);
    $display("test %s finished", name);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 32'h2408E0DE;
    num_errors = 0;
    num_checks = 0;
    cyc = 0;
    rst = 1'b1;
    {stb_n_r, en_r, txd_r, bdom_r} = 4'h2;
    {bwake, lwake, cuv, buv, bcon, ot} = 6'h00;
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    step(1, ex(TMC_STANDBY, 1'b0, 1'b1, 1'b1));
    done_test("reset");

    pins(1'b1, 1'b1);
    bdom_r = $random(seed);
    step(D, ex(TMC_NORMAL, 1'b0, 1'b1, 1'b1));
    pins(1'b1, 1'b0);
    bdom_r = $random(seed);
    step(D, ex(TMC_RXONLY, 1'b0, 1'b1, 1'b1));
    // Power-up raised only once out of normal, where it would be cleared
    bcon = 1'b1;
    step(D, ex(TMC_RXONLY, 1'b0, 1'b0, 1'b1));
    pins(1'b1, 1'b1);
    step(D, ex(TMC_NORMAL, 1'b0, 1'b1, 1'b1));
    pins(1'b1, 1'b0);
    step(D, ex(TMC_RXONLY, 1'b0, 1'b1, 1'b1));
    done_test("active modes");

    to_sleep();
    pins(1'b0, 1'b0);
    step(D, ex(TMC_SLEEP, 1'b0, 1'b1, 1'b1));
    for (k = 0; k < 2; k++) begin
      pins(1'b0, 1'b1);
      if (k == 0) bwake = 1'b1;
      else lwake = 1'b1;
      step(D, ex(TMC_STANDBY, 1'b0, 1'b0, 1'b0));
      {bwake, lwake} = 2'b00;
      pins(1'b1, 1'b1);
      step(D, ex(TMC_NORMAL, 1'b0, 1'b1, 1'b1));
      to_sleep();
    end
    pins(1'b1, 1'b0);
    step(D, ex(TMC_RXONLY, 1'b0, 1'b1, 1'b1));
    done_test("sleep and wake");

    pins(1'b1, 1'b1);
    cuv = 1'b1;
    step(2 * D, ex(TMC_SLEEP, 1'b0, 1'b1, 1'b1));
    cuv = 1'b0;
    bcon = 1'b0;
    step(D, ex(TMC_SLEEP, 1'b0, 1'b1, 1'b1));
    bcon = 1'b1;
    step(2 * D, ex(TMC_NORMAL, 1'b0, 1'b1, 1'b1));
    buv = 1'b1;
    step(D, ex(TMC_STANDBY, 1'b0, 1'b1, 1'b1));
    buv = 1'b0;
    step(D, ex(TMC_NORMAL, 1'b0, 1'b1, 1'b1));
    done_test("undervoltage");

    bdom_r = 1'b0;
    ot = 1'b1;
    step(D, ex(TMC_NORMAL, 1'b1, 1'b1, 1'b1));
    // Leave normal while still hot: normal with recessive data clears the failure
    pins(1'b1, 1'b0);
    step(D, ex(TMC_RXONLY, 1'b1, 1'b0, 1'b1));
    ot = 1'b0;
    step(D, ex(TMC_RXONLY, 1'b1, 1'b0, 1'b1));
    pins(1'b1, 1'b1);
    step(D, ex(TMC_NORMAL, 1'b0, 1'b1, 1'b1));
    txd_r = 1'b0;
    step(4, ex(TMC_NORMAL, 1'b0, 1'b1, 1'b1));
    step(3 * D, ex(TMC_NORMAL, 1'b1, 1'b1, 1'b1));
    txd_r = 1'b1;
    bdom_r = 1'b1;
    step(D, ex(TMC_NORMAL, 1'b0, 1'b1, 1'b1));
    done_test("failure");
    summarize();
  end
endmodule
`default_nettype wire
